// File: hw/kmlm_top.sv
// four-digit led scanner sharing its commons with a key matrix scan
`timescale 1ns/1ps
module kmlm_top #(
    parameter int SCAN_CYCLES   = kmlm_pkg::SCAN_CYCLES,
    parameter int SETTLE_CYCLES = kmlm_pkg::SETTLE_CYCLES
) (
    input  wire logic       CLOCK,       // 100 MHz system clock
    input  wire logic       RESETN,      // async reset, active low
    input  wire logic [1:0] KEY_RETURN,  // key return pins, high = pressed
    output logic      [3:0] COMMON,      // digit commons, high = selected
    output logic      [7:0] SEGMENT      // {dp,g,f,e,d,c,b,a}, low = lit
);
    kmlm_tmr_if scan_if ();
    kmlm_tmr_if settle_if ();

    // digit interval timer, free running once started
    kmlm_timer #(.ONESHOT(0), .LOAD(SCAN_CYCLES)) u_scan_timer (
        .CLOCK  (CLOCK),
        .RESETN (RESETN),
        .tmr    (scan_if.unit)
    );

    // settling timer, one shot per common change
    kmlm_timer #(.ONESHOT(1), .LOAD(SETTLE_CYCLES)) u_settle_timer (
        .CLOCK  (CLOCK),
        .RESETN (RESETN),
        .tmr    (settle_if.unit)
    );

    logic                   started;
    logic [1:0]             ret_meta;
    logic [1:0]             ret_sync;
    logic [1:0]             digit;
    logic [1:0]             offset;
    logic [2:0]             data_set;
    logic [7:0]             step_cnt;
    logic                   blank;
    logic [3:0]             last_code;
    logic [1:0]             match_cnt;
    kmlm_pkg::kmlm_mode_type mode;

    // timer control
    wire scan_tick   = scan_if.expire;
    wire sample_fire = settle_if.expire;
    assign scan_if.start   = !started;
    assign settle_if.start = scan_tick;

    // scan step decode
    wire [1:0] next_digit  = digit + 2'h1;
    wire [3:0] next_common = 4'h1 << next_digit;

    // key sampling decode: the code pairs the driven column with returns
    wire       key_seen    = |ret_sync;
    wire [3:0] sample_code = {digit, ret_sync};
    wire       same_code   = (sample_code == last_code);
    wire       released    = !key_seen && (digit == last_code[3:2]);
    wire       accept      = sample_fire && key_seen && same_code &&
                             (match_cnt == kmlm_pkg::MATCH_NEEDED - 2'h1);
    wire [1:0] next_match  =
        !sample_fire ? match_cnt :
        released     ? 2'h0 :
        !key_seen    ? match_cnt :
        !same_code   ? 2'h1 :
        (match_cnt == kmlm_pkg::MATCH_NEEDED) ? match_cnt :
        match_cnt + 2'h1;

    wire acc_blink  = accept && sample_code == kmlm_pkg::KEY_BLINK;
    wire acc_right  = accept && sample_code == kmlm_pkg::KEY_RIGHT;
    wire acc_left   = accept && sample_code == kmlm_pkg::KEY_LEFT;
    wire acc_update = accept && sample_code == kmlm_pkg::KEY_UPDATE;
    wire acc_reset  = accept && sample_code == kmlm_pkg::KEY_RESET;

    // step timing for blink and rotation, in whole digit intervals
    wire step_tick = scan_tick &&
                     (step_cnt == kmlm_pkg::STEP_SCANS - 8'h1);
    wire [2:0] next_set = (data_set == kmlm_pkg::LAST_SET) ?
                          kmlm_pkg::INIT_SET : data_set + 3'h1;

    // pattern for the digit now selected; rotation shifts the read index
    wire [1:0] show_pos = digit + offset;
    wire [7:0] lit      = kmlm_pkg::DATA_TABLE[data_set][show_pos];
    wire [7:0] next_segment = blank ? kmlm_pkg::SEGMENTS_OFF : ~lit;

    // return pins are asynchronous to the clock
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            ret_meta <= 2'h0;
            ret_sync <= 2'h0;
        end else begin
            ret_meta <= KEY_RETURN;
            ret_sync <= ret_meta;
        end
    end

    // one-hot common walk; only one common is ever driven
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            started <= 1'b0;
            digit   <= kmlm_pkg::INIT_DIGIT;
            COMMON  <= kmlm_pkg::INIT_COMMON;
        end else begin
            started <= 1'b1;
            if (scan_tick) begin
                digit  <= next_digit;
                COMMON <= next_common;
            end
        end
    end

    // segments lag the common by one cycle, far below visibility
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            SEGMENT <= kmlm_pkg::SEGMENTS_OFF;
        end else begin
            SEGMENT <= next_segment;
        end
    end

    // debounce history: code of the last press and agreeing samples
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            last_code <= 4'h0;
            match_cnt <= 2'h0;
        end else begin
            match_cnt <= next_match;
            if (sample_fire && key_seen) begin
                last_code <= sample_code;
            end
        end
    end

    // mode is held until another accepted key replaces it
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            mode <= kmlm_pkg::MODE_STATIC;
        end else if (acc_blink) begin
            mode <= kmlm_pkg::MODE_BLINK;
        end else if (acc_right) begin
            mode <= kmlm_pkg::MODE_RIGHT;
        end else if (acc_left) begin
            mode <= kmlm_pkg::MODE_LEFT;
        end else if (acc_reset) begin
            mode <= kmlm_pkg::MODE_STATIC;
        end
    end

    // step counter shared by blink and rotation
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            step_cnt <= 8'h0;
        end else if (step_tick) begin
            step_cnt <= 8'h0;
        end else if (scan_tick) begin
            step_cnt <= step_cnt + 8'h1;
        end
    end

    // display contents: data set, rotation offset and blink phase
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            data_set <= kmlm_pkg::INIT_SET;
            offset   <= 2'h0;
            blank    <= 1'b0;
        end else if (acc_reset) begin
            data_set <= kmlm_pkg::INIT_SET;
            offset   <= 2'h0;
            blank    <= 1'b0;
        end else if (acc_update) begin
            data_set <= next_set;
        end else if (step_tick) begin
            unique case (mode)
                kmlm_pkg::MODE_STATIC: blank  <= 1'b0;
                kmlm_pkg::MODE_BLINK:  blank  <= !blank;
                kmlm_pkg::MODE_RIGHT: begin
                    blank  <= 1'b0;
                    offset <= offset - 2'h1;
                end
                kmlm_pkg::MODE_LEFT: begin
                    blank  <= 1'b0;
                    offset <= offset + 2'h1;
                end
            endcase
        end
    end

    // checks
    property p_onehot_common;
        @(posedge CLOCK) disable iff (!RESETN)
        $onehot(COMMON);
    endproperty
    a_onehot_common: assert property (p_onehot_common)
        else $error("commons not one-hot");

    property p_scan_step;
        @(posedge CLOCK) disable iff (!RESETN)
        scan_tick |=> COMMON == {$past(COMMON[2:0]), $past(COMMON[3])};
    endproperty
    a_scan_step: assert property (p_scan_step)
        else $error("common did not advance on scan tick");

    property p_common_still;
        @(posedge CLOCK) disable iff (!RESETN)
        !scan_tick |=> $stable(COMMON);
    endproperty
    a_common_still: assert property (p_common_still)
        else $error("common moved without scan tick");

    property p_settle_gap;
        @(posedge CLOCK) disable iff (!RESETN)
        scan_tick |=> (!sample_fire)[*8];
    endproperty
    a_settle_gap: assert property (p_settle_gap)
        else $error("keys sampled before settling");

    property p_accept_history;
        @(posedge CLOCK) disable iff (!RESETN)
        accept |-> match_cnt == 2'h2 && last_code == sample_code;
    endproperty
    a_accept_history: assert property (p_accept_history)
        else $error("key accepted without three samples");

    property p_blink_dark;
        @(posedge CLOCK) disable iff (!RESETN)
        blank |=> SEGMENT == kmlm_pkg::SEGMENTS_OFF;
    endproperty
    a_blink_dark: assert property (p_blink_dark)
        else $error("segments lit in blink off phase");

    property p_rotate_right;
        @(posedge CLOCK) disable iff (!RESETN)
        step_tick && mode == kmlm_pkg::MODE_RIGHT && !accept
            |=> offset == $past(offset) - 2'h1;
    endproperty
    a_rotate_right: assert property (p_rotate_right)
        else $error("right rotation missed");

    property p_rotate_left;
        @(posedge CLOCK) disable iff (!RESETN)
        step_tick && mode == kmlm_pkg::MODE_LEFT && !accept
            |=> offset == $past(offset) + 2'h1;
    endproperty
    a_rotate_left: assert property (p_rotate_left)
        else $error("left rotation missed");

    property p_update_set;
        @(posedge CLOCK) disable iff (!RESETN)
        acc_update |=> data_set != $past(data_set) &&
            data_set == (($past(data_set) == kmlm_pkg::LAST_SET) ?
                         kmlm_pkg::INIT_SET : $past(data_set) + 3'h1);
    endproperty
    a_update_set: assert property (p_update_set)
        else $error("update did not load next data");

    property p_reset_data;
        @(posedge CLOCK) disable iff (!RESETN)
        acc_reset |=> data_set == kmlm_pkg::INIT_SET && offset == 2'h0
            ##1 SEGMENT == ~kmlm_pkg::DATA_TABLE[0][$past(digit)];
    endproperty
    a_reset_data: assert property (p_reset_data)
        else $error("reset key did not restore initial data");

endmodule : kmlm_top

// File: inc/kmlm_pkg.sv
// shared constants and types of the key matrix and led scanner
package kmlm_pkg;

    // clock and timing
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int SCAN_TIME_NS    = 4170000;  // per-digit interval, 4.17 ms
    localparam int SETTLE_TIME_NS  = 2000000;  // settling delay, 2 ms
    // longest time rounds down, least time rounds up
    localparam int SCAN_CYCLES   = SCAN_TIME_NS / CLOCK_PERIOD_NS;
    localparam int SETTLE_CYCLES =
        (SETTLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int TIMER_WIDTH   = 20;

    // display geometry
    localparam int DIGITS        = 4;
    localparam int SEGMENTS      = 8;
    localparam int DATA_SETS     = 6;
    localparam logic [2:0] LAST_SET   = 3'h5;
    localparam logic [2:0] INIT_SET   = 3'h0;
    localparam logic [1:0] INIT_DIGIT = 2'h0;
    localparam logic [3:0] INIT_COMMON = 4'h1;
    localparam logic [7:0] SEGMENTS_OFF = 8'hff;

    // blink and rotate step, counted in digit intervals
    localparam logic [7:0] STEP_SCANS = 8'h3c;

    // debounce: samples that must agree
    localparam logic [1:0] MATCH_NEEDED = 2'h3;

    // key codes: {driven digit, return lines}
    localparam logic [3:0] KEY_BLINK  = 4'h1;
    localparam logic [3:0] KEY_RIGHT  = 4'h5;
    localparam logic [3:0] KEY_LEFT   = 4'h9;
    localparam logic [3:0] KEY_UPDATE = 4'h2;
    localparam logic [3:0] KEY_RESET  = 4'h6;

    // display modes, gray coded along the usual path
    typedef enum logic [1:0] {
        MODE_STATIC = 2'b00,
        MODE_BLINK  = 2'b01,
        MODE_RIGHT  = 2'b11,
        MODE_LEFT   = 2'b10
    } kmlm_mode_type;

    // lit-segment patterns {dp,g,f,e,d,c,b,a}, set 0 is the initial data
    localparam logic [0:5][0:3][7:0] DATA_TABLE = '{
        '{8'h06, 8'h5b, 8'h4f, 8'h66},
        '{8'h6d, 8'h7d, 8'h07, 8'h7f},
        '{8'h6f, 8'h77, 8'h7c, 8'h39},
        '{8'h5e, 8'h79, 8'h71, 8'h3f},
        '{8'hbf, 8'h86, 8'hdb, 8'hcf},
        '{8'h40, 8'h40, 8'h40, 8'h40}
    };

endpackage : kmlm_pkg

// File: inc/kmlm_tmr_if.sv
// start and expiry signals between the scanner and an interval timer
`timescale 1ns/1ps
interface kmlm_tmr_if;
    logic start;   // pulse: load and run the timer
    logic expire;  // pulse: interval elapsed

    modport ctl  (output start, input expire);
    modport unit (input start, output expire);
endinterface : kmlm_tmr_if

// File: hw/kmlm_timer.sv
// interval timer unit: periodic or one-shot down counter
`timescale 1ns/1ps
module kmlm_timer #(
    parameter int ONESHOT = 0,
    parameter int LOAD    = 1
) (
    input  wire logic CLOCK,    // system clock
    input  wire logic RESETN,   // async reset, active low
    kmlm_tmr_if.unit  tmr       // start in, expire out
);
    localparam logic [kmlm_pkg::TIMER_WIDTH-1:0] RELOAD =
        kmlm_pkg::TIMER_WIDTH'(LOAD - 1);

    logic [kmlm_pkg::TIMER_WIDTH-1:0] count;
    logic                             running;
    logic                             expire;
    wire                              at_zero = (count == '0);

    assign tmr.expire = expire;

    // a start always reloads; a one-shot stops itself after one expiry
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            count   <= '0;
            running <= 1'b0;
            expire  <= 1'b0;
        end else begin
            expire <= running && at_zero && !tmr.start;
            if (tmr.start) begin
                count   <= RELOAD;
                running <= 1'b1;
            end else if (running && at_zero) begin
                count   <= RELOAD;
                running <= (ONESHOT == 0);
            end else if (running) begin
                count <= count - 1'b1;
            end
        end
    end

    // no expiry in the second cycle after an undisturbed start
    property p_timer_period;
        @(posedge CLOCK) disable iff (!RESETN)
        tmr.start ##1 (!tmr.start)[*2] |-> !expire;
    endproperty
    a_timer_period: assert property (p_timer_period)
        else $error("timer expired too early after start");

endmodule : kmlm_timer

// File: dv/kmlm_keypad.sv
// passive two-by-four key matrix behind the shared digit commons
`timescale 1ns/1ps
module kmlm_keypad (
    input  wire logic [3:0]      common,     // driven column, high = active
    input  wire logic [3:0][1:0] pressed,    // closed keys per column
    output logic      [1:0]      key_return  // high = closed key in column
);
    // series diodes keep idle columns out; the pull-down holds a return low
    always_comb begin
        key_return = 2'h0;
        for (int d = 0; d < 4; d++) begin
            key_return = key_return | ({2{common[d]}} & pressed[d]);
        end
    end
endmodule : kmlm_keypad

// File: dv/tb_kmlm_top.sv
// self-checking bench of the key matrix and led scanner
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin \
    err_count++; $display("mismatch %s exp %h got %h", what, exp, got); end end
module tb_kmlm_top;
    localparam int SCAN   = 40;
    localparam int SETTLE = 10;
    logic            clock;
    logic            resetn;
    logic [3:0][1:0] pressed;
    logic [1:0]      key_return;
    logic [3:0]      common;
    logic [7:0]      segment;
    logic [7:0]      frame [4];
    int              err_count;
    int              checked;

    kmlm_top #(.SCAN_CYCLES(SCAN), .SETTLE_CYCLES(SETTLE)) dut (
        .CLOCK(clock), .RESETN(resetn), .KEY_RETURN(key_return),
        .COMMON(common), .SEGMENT(segment));
    kmlm_keypad pad (.common(common), .pressed(pressed),
        .key_return(key_return));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // outputs are looked at 1 ns after the edge, once updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    task automatic summarize();
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // bounded wait for the next common step, n = cycles waited
    task automatic wait_step(output int n);
        logic [3:0] c;
        c = common;
        n = 0;
        while (common === c && n < 2 * SCAN) begin
            cyc(1);
            n++;
        end
    endtask : wait_step

    // one pass of the four digits; segments lag the common by one cycle
    task automatic read_frame();
        int n;
        for (int i = 0; i < 4; i++) begin
            wait_step(n);
            cyc(2);
            `CHK("common one-hot", 1'b1, $onehot(common))
            for (int d = 0; d < 4; d++) begin
                if (common[d] === 1'b1) frame[d] = segment;
            end
        end
    endtask : read_frame

    task automatic check_set(input int set, input int off);
        logic [7:0] e;
        read_frame();
        for (int p = 0; p < 4; p++) begin
            e = ~kmlm_pkg::DATA_TABLE[set][(p + off) % 4];
            `CHK("segment", e, frame[p])
        end
    endtask : check_set

    // offset of set 0 on show, 4 = all dark; a frame cut by a step retries
    task automatic look(output int off);
        off = -1;
        for (int t = 0; t < 2 && off < 0; t++) begin
            read_frame();
            if ((frame[0] & frame[1] & frame[2] & frame[3]) === 8'hff)
                off = 4;
            for (int o = 0; o < 4; o++) begin
                if (frame[0] === ~kmlm_pkg::DATA_TABLE[0][o] &&
                    frame[1] === ~kmlm_pkg::DATA_TABLE[0][(o + 1) % 4] &&
                    frame[2] === ~kmlm_pkg::DATA_TABLE[0][(o + 2) % 4] &&
                    frame[3] === ~kmlm_pkg::DATA_TABLE[0][(o + 3) % 4]) off = o;
            end
        end
    endtask : look

    // two looks one step apart: a step is 60 intervals, 15 frames
    task automatic two_looks(output int o1, output int o2);
        look(o1);
        repeat (14) read_frame();
        look(o2);
    endtask : two_looks

    task automatic press_key(input logic [3:0] code, input int frames);
        @(posedge clock);
        pressed[code[3:2]] <= code[1:0];
        cyc(frames * 4 * SCAN);
        @(posedge clock);
        pressed <= '0;
        cyc(8 * SCAN);
    endtask : press_key

    task automatic t_scan();
        logic [3:0] c;
        int n;
        wait_step(n);
        for (int i = 0; i < 5; i++) begin
            c = common;
            wait_step(n);
            `CHK("digit interval", SCAN, n)
            `CHK("next common", {c[2:0], c[3]}, common)
        end
    endtask : t_scan

    // codes without a function and both returns high must not act
    task automatic t_update();
        logic [3:0] bad [5] = '{4'h3, 4'h7, 4'ha, 4'hd, 4'he};
        for (int s = 1; s <= 6; s++) begin
            press_key(kmlm_pkg::KEY_UPDATE, 4);
            check_set(s % 6, 0);
        end
        press_key(kmlm_pkg::KEY_UPDATE, 2);
        check_set(0, 0);
        press_key(kmlm_pkg::KEY_UPDATE, 4);
        for (int k = 0; k < 5; k++) begin
            press_key(bad[k], 4);
            check_set(1, 0);
        end
        press_key(kmlm_pkg::KEY_RESET, 4);
        check_set(0, 0);
    endtask : t_update

    task automatic t_rotate();
        int o1;
        int o2;
        press_key(kmlm_pkg::KEY_RIGHT, 4);
        two_looks(o1, o2);
        `CHK("right found", 1'b1, o1 >= 0 && o1 < 4)
        `CHK("right step", (o1 + 3) % 4, o2)
        press_key(kmlm_pkg::KEY_LEFT, 4);
        two_looks(o1, o2);
        `CHK("left found", 1'b1, o1 >= 0 && o1 < 4)
        `CHK("left step", (o1 + 1) % 4, o2)
        press_key(kmlm_pkg::KEY_RESET, 4);
        two_looks(o1, o2);
        `CHK("static offset", 0, o2)
    endtask : t_rotate

    task automatic t_blink();
        int o1;
        int o2;
        int o3;
        press_key(kmlm_pkg::KEY_BLINK, 4);
        two_looks(o1, o2);
        repeat (14) read_frame();
        look(o3);
        `CHK("blink phase", 1'b1, o1 == 0 || o1 == 4)
        `CHK("blink toggle", 4 - o1, o2)
        `CHK("blink even", o1, o3)
        press_key(kmlm_pkg::KEY_RESET, 4);
        check_set(0, 0);
    endtask : t_blink

    // a hang counts as a failure and ends the run the usual way;
    // the scenarios need about 34000 cycles, so this leaves more than twice that
    initial begin
        cyc(80000);
        err_count++;
        summarize();
    end

    initial begin
        resetn = 1'b0;
        pressed = '0;
        err_count = 0;
        checked = 0;
        cyc(20);
        `CHK("reset common", 4'h1, common)
        `CHK("reset segment", 8'hff, segment)
        @(posedge clock);
        resetn <= 1'b1;
        cyc(1);
        `CHK("first segment", 8'hf9, segment)
        t_scan();
        t_update();
        t_rotate();
        t_blink();
        summarize();
    end
endmodule : tb_kmlm_top
